// File: ebs_pkg.sv
// Purpose: constants and carriers for the external bus cycle sequencer
// Assumes: 16-bit multiplexed address/data bus, 6 page lines, 16K pages
// Notes: the system side posts one access at a time; the link side runs it
//
// Summary of operation
// - linear address is the page value placed above address bits 13..0
// - bank holding a linear address equals that address divided by 0x4000
// - read start: address out, read/write high, strobe low if address odd
// - chip select goes low only after address, read/write, strobe valid
// - no read acknowledge: fixed end latches data, strobe and select high
// - write start: read/write low, address out, strobe low odd or wide word
// - write data driven after select; end drops select and floats bus
// - the two halves of a split write keep read/write low with no high pulse
// - unstretched access is one bus-clock period, states S0 to S3
// - S0: new address, strobe and read/write out, both selects high
// - S1: address, strobe, read/write held; select asserted low
// - S2: address removed; write data driven or bus left floating
// - each stretch lengthens S2 by one bus-clock period, up to three
// - S3: select, strobe, read/write held; write data still driven
// - narrow mode splits word requests into two byte accesses, upper port
// - page enable, expanded, window 0x8000-0xBFFF: page on page lines
package ebs_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int PAGE_W = 6;
	localparam int PAGE_SHIFT = 14;
	localparam logic [19:0] PAGE_SIZE = 20'h04000;
	localparam logic [15:0] WIN_LO = 16'h8000;
	localparam logic [15:0] WIN_HI = 16'hbfff;
	localparam logic [3:0] PAGE_FILL = 4'hf;
	localparam logic [1:0] PH_S0 = 2'h0;
	localparam logic [1:0] PH_S2 = 2'h2;
	localparam logic [1:0] PH_S3 = 2'h3;
	localparam logic [15:0] AD_RST = 16'h0000;
	localparam logic [1:0] STRETCH_RST = 2'h0;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_S0 = 5'b00010,
		ST_S1 = 5'b00100,
		ST_S2 = 5'b01000,
		ST_S3 = 5'b10000
	} ebs_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic write;
		logic word;
		logic [DATA_W-1:0] wdata;
		logic [1:0] stretch;
		logic [PAGE_W-1:0] program_page_select;
		logic narrow;
		logic expanded;
		logic page_lines_output_enable;
		logic emul_sel;
	} ebs_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] ad;
		logic ad_oe;
		logic rw;
		logic low_byte_strobe_n;
		logic emulation_chip_select_n;
		logic expansion_chip_select_n;
		logic bus_clock_out;
		logic [PAGE_W-1:0] extended_page_address;
	} ebs_pins_t;

	function automatic logic [19:0] ebs_linear(input logic [5:0] page,
		input logic [15:0] addr);
		ebs_linear = {page, addr[13:0]};
	endfunction

	function automatic logic [5:0] ebs_bank_of(input logic [19:0] linear);
		logic [19:0] q;
		q = linear / PAGE_SIZE;
		ebs_bank_of = q[5:0];
	endfunction

endpackage

// File: ebs_sync2.sv
// Purpose: two-flop level synchroniser
// Assumes: rst_n_in is synchronous to clk_in; tie high when unused
// Notes: the first flop feeds only the second
`timescale 1ns/1ps
module ebs_sync2 (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// level in and out
	input wire logic d_in,
	output logic q_out
);
	import ebs_pkg::*;

	logic meta_ff;
	logic sync_ff;

	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end
		else
		begin
			meta_ff <= d_in;
			sync_ff <= meta_ff;
		end
	end

	assign q_out = sync_ff;
endmodule

// File: ebs_bus_sequencer.sv
// Purpose: multiplexed external bus read/write cycle sequencer
// Assumes: link_clk_in is four times the bus clock; one access in flight
// Notes: request words cross by toggle handshake and stay still meanwhile
`timescale 1ns/1ps
module ebs_bus_sequencer (
	// system clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// link clock
	input wire logic link_clk_in,
	// request side
	input wire ebs_pkg::ebs_req_t req_in,
	input wire logic req_valid_in,
	output logic req_ready_out,
	// answer side
	output logic rsp_valid_out,
	output logic [ebs_pkg::DATA_W-1:0] rsp_rdata_out,
	output logic [19:0] rsp_linear_out,
	// external bus pins
	output ebs_pkg::ebs_pins_t pins_out,
	input wire logic [ebs_pkg::DATA_W-1:0] ad_in
);
	import ebs_pkg::*;

	// system domain
	logic busy_ff;
	logic req_tgl_ff;
	logic done_seen_ff;
	logic rsp_valid_ff;
	logic [DATA_W-1:0] rsp_rdata_ff;
	logic [19:0] rsp_linear_ff;
	ebs_req_t hold_ff;
	logic done_s;
	wire accept = req_valid_in & ~busy_ff;
	wire done_evt = done_s ^ done_seen_ff;

	// link domain
	logic link_rst_n;
	logic req_s;
	logic req_seen_ff;
	logic done_tgl_ff;
	ebs_state_t st_ff;
	ebs_state_t nxt_st;
	logic [1:0] ph_ff;
	logic [1:0] str_cnt_ff;
	logic half_ff;
	ebs_req_t cur_ff;
	logic [DATA_W-1:0] rdata_ff;
	ebs_pins_t pins_ff;
	ebs_pins_t nxt_pins;

	ebs_sync2 u_done_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.d_in(done_tgl_ff),
		.q_out(done_s)
	);

	// reset of the link side is the system reset carried across
	ebs_sync2 u_rst_sync (
		.clk_in(link_clk_in),
		.rst_n_in(1'b1),
		.d_in(rst_n_in),
		.q_out(link_rst_n)
	);

	ebs_sync2 u_req_sync (
		.clk_in(link_clk_in),
		.rst_n_in(link_rst_n),
		.d_in(req_tgl_ff),
		.q_out(req_s)
	);

	assign req_ready_out = ~busy_ff;
	assign rsp_valid_out = rsp_valid_ff;
	assign rsp_rdata_out = rsp_rdata_ff;
	assign rsp_linear_out = rsp_linear_ff;
	assign pins_out = pins_ff;

	// hold_ff is frozen while busy, so the link side may read it freely
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			busy_ff <= 1'b0;
			req_tgl_ff <= 1'b0;
			hold_ff <= '0;
		end
		else if (accept)
		begin
			busy_ff <= 1'b1;
			req_tgl_ff <= ~req_tgl_ff;
			hold_ff <= req_in;
		end
		else if (done_evt)
		begin
			busy_ff <= 1'b0;
		end
	end

	// rdata_ff is loaded on the same link edge that flips the done toggle
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			done_seen_ff <= 1'b0;
			rsp_valid_ff <= 1'b0;
			rsp_rdata_ff <= AD_RST;
			rsp_linear_ff <= 20'h00000;
		end
		else
		begin
			done_seen_ff <= done_s;
			rsp_valid_ff <= done_evt;
			if (done_evt)
			begin
				rsp_rdata_ff <= rdata_ff;
				rsp_linear_ff <= ebs_linear(hold_ff.program_page_select,
					hold_ff.addr);
			end
		end
	end

	// link side decode
	wire pending = req_s ^ req_seen_ff;
	wire [1:0] nxt_ph = ph_ff + 2'h1;
	wire split = cur_ff.narrow & cur_ff.word;
	wire more_half = split & ~half_ff;
	wire start_new = (st_ff == ST_IDLE) & pending & (ph_ff == PH_S3);
	wire s2_done = (st_ff == ST_S2) & (ph_ff == PH_S2) &
		(str_cnt_ff == 2'h0);
	wire s2_dec = (st_ff == ST_S2) & (ph_ff == PH_S2) &
		(str_cnt_ff != 2'h0);
	wire s3_end = (st_ff == ST_S3);
	wire half_step = s3_end & more_half;
	wire finish = s3_end & ~more_half;

	// values for the coming cycle
	wire ebs_req_t nxt_cur = start_new ? hold_ff : cur_ff;
	wire nxt_half = start_new ? 1'b0 : (half_step ? 1'b1 : half_ff);
	wire nxt_split = nxt_cur.narrow & nxt_cur.word;
	wire [ADDR_W-1:0] nxt_addr = nxt_cur.addr +
		{{(ADDR_W-1){1'b0}}, nxt_half};
	wire nxt_odd = nxt_addr[0];
	wire nxt_in_win = (nxt_addr >= WIN_LO) & (nxt_addr <= WIN_HI);
	wire page_show = nxt_cur.page_lines_output_enable & nxt_cur.expanded &
		nxt_in_win;
	wire [PAGE_W-1:0] nxt_page = page_show ? nxt_cur.program_page_select :
		{PAGE_FILL, nxt_addr[15:14]};
	wire nxt_strobe = nxt_odd |
		(nxt_cur.write & nxt_cur.word & ~nxt_cur.narrow);
	wire [7:0] nxt_byte = (nxt_split & nxt_half) ? nxt_cur.wdata[7:0] :
		nxt_cur.wdata[15:8];
	wire [DATA_W-1:0] nxt_wbus = nxt_cur.narrow ? {nxt_byte, 8'h00} :
		nxt_cur.wdata;
	wire nxt_addr_ph = (nxt_st == ST_S0) | (nxt_st == ST_S1);
	wire nxt_data_ph = (nxt_st == ST_S2) | (nxt_st == ST_S3);
	wire nxt_active = nxt_addr_ph | nxt_data_ph;
	wire nxt_sel = (nxt_st == ST_S1) | nxt_data_ph;

	// read capture at the fixed end of S3, no acknowledge awaited
	wire [DATA_W-1:0] cap_data = ~cur_ff.narrow ? ad_in :
		(split ? (half_ff ? {rdata_ff[15:8], ad_in[15:8]} :
		{ad_in[15:8], rdata_ff[7:0]}) :
		{8'h00, ad_in[15:8]});

	always_comb
	begin
		nxt_st = st_ff;
		case (st_ff)
			ST_IDLE:
			begin
				if (start_new)
					nxt_st = ST_S0;
			end
			ST_S0:
				nxt_st = ST_S1;
			ST_S1:
				nxt_st = ST_S2;
			ST_S2:
			begin
				if (s2_done)
					nxt_st = ST_S3;
			end
			ST_S3:
				nxt_st = more_half ? ST_S0 : ST_IDLE;
			default:
				nxt_st = ST_IDLE;
		endcase
	end

	always_comb
	begin
		nxt_pins = '0;
		nxt_pins.bus_clock_out = nxt_ph[1];
		nxt_pins.extended_page_address = nxt_page;
		// address in S0/S1, write data in S2/S3, floating on reads
		nxt_pins.ad = nxt_addr_ph ? nxt_addr :
			(nxt_data_ph & nxt_cur.write ? nxt_wbus : AD_RST);
		nxt_pins.ad_oe = nxt_addr_ph |
			(nxt_data_ph & nxt_cur.write);
		// read/write stays low from one write half straight into the next
		nxt_pins.rw = nxt_active ? ~nxt_cur.write : 1'b1;
		nxt_pins.low_byte_strobe_n = ~(nxt_active & nxt_strobe);
		nxt_pins.emulation_chip_select_n =
			~(nxt_sel & nxt_cur.emul_sel);
		nxt_pins.expansion_chip_select_n =
			~(nxt_sel & ~nxt_cur.emul_sel);
	end

	always_ff @(posedge link_clk_in)
	begin
		if (!link_rst_n)
		begin
			st_ff <= ST_IDLE;
			ph_ff <= PH_S0;
			cur_ff <= '0;
			half_ff <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
			ph_ff <= nxt_ph;
			cur_ff <= nxt_cur;
			half_ff <= nxt_half;
		end
	end

	always_ff @(posedge link_clk_in)
	begin
		if (!link_rst_n)
			str_cnt_ff <= STRETCH_RST;
		else if (st_ff == ST_S1)
			str_cnt_ff <= cur_ff.stretch;
		else if (s2_dec)
			str_cnt_ff <= str_cnt_ff - 2'h1;
	end

	always_ff @(posedge link_clk_in)
	begin
		if (!link_rst_n)
		begin
			req_seen_ff <= 1'b0;
			done_tgl_ff <= 1'b0;
			rdata_ff <= AD_RST;
		end
		else
		begin
			if (start_new)
				req_seen_ff <= req_s;
			if (s3_end & ~cur_ff.write)
				rdata_ff <= cap_data;
			if (finish)
				done_tgl_ff <= ~done_tgl_ff;
		end
	end

	always_ff @(posedge link_clk_in)
	begin
		if (!link_rst_n)
		begin
			pins_ff <= '0;
			pins_ff.rw <= 1'b1;
			pins_ff.low_byte_strobe_n <= 1'b1;
			pins_ff.emulation_chip_select_n <= 1'b1;
			pins_ff.expansion_chip_select_n <= 1'b1;
		end
		else
			pins_ff <= nxt_pins;
	end

endmodule

// File: ebs_bus_sequencer_properties.sv
// Purpose: bus phase checks for the cycle sequencer
// Assumes: bench holds req_in still for the whole access
// Notes: bus checks run on the link clock only
`timescale 1ns/1ps
module ebs_bus_sequencer_checker (
	// clocks and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic link_clk_in,
	// request and answer
	input wire ebs_pkg::ebs_req_t req_in,
	input wire logic req_valid_in,
	input wire logic req_ready_out,
	input wire logic rsp_valid_out,
	input wire logic [ebs_pkg::DATA_W-1:0] rsp_rdata_out,
	input wire logic [19:0] rsp_linear_out,
	// bus pins
	input wire ebs_pkg::ebs_pins_t pins_out,
	input wire logic [ebs_pkg::DATA_W-1:0] ad_in
);
	import ebs_pkg::*;
	wire logic cs_n = pins_out.emulation_chip_select_n &
		pins_out.expansion_chip_select_n;
	wire logic hi = pins_out.bus_clock_out;
	default clocking @(posedge link_clk_in); endclocking
	default disable iff (!rst_n_in);
	a_sel_after_addr: assert property ($fell(cs_n) |-> !hi &&
		$stable(pins_out.ad) && $stable(pins_out.rw)) else $error("select early");
	// free-running bus clock also falls inside a stretched S2
	a_s0_selects_high: assert property ($fell(hi) &&
		req_in.stretch == 2'h0 |-> cs_n)
		else $error("select low in first phase");
	a_sel_choice: assert property ($fell(cs_n) |->
		pins_out.emulation_chip_select_n == !req_in.emul_sel &&
		pins_out.expansion_chip_select_n == req_in.emul_sel)
		else $error("wrong chip select");
	a_sel_length: assert property ($fell(cs_n) |->
		(!cs_n)[*3] ##[1:13] cs_n) else $error("select length wrong");
	a_read_floats: assert property (!cs_n && pins_out.rw && hi |->
		!pins_out.ad_oe) else $error("read bus driven");
	a_write_drives: assert property (!cs_n && !pins_out.rw && hi |->
		pins_out.ad_oe) else $error("write data not driven");
	a_held_while_sel: assert property (!cs_n && !$past(cs_n) |->
		$stable(pins_out.rw) && $stable(pins_out.low_byte_strobe_n))
		else $error("control moved while selected");
	a_strobe_level: assert property ($fell(cs_n) |->
		pins_out.low_byte_strobe_n == !(pins_out.ad[0] |
		(!pins_out.rw & req_in.word & !req_in.narrow))) else $error("strobe");
	a_rw_no_pulse: assert property ($rose(cs_n) && pins_out.ad_oe &&
		!$past(pins_out.rw) |-> !pins_out.rw) else $error("rw pulsed high");
	a_page_lines: assert property (!cs_n && req_in.expanded &&
		req_in.page_lines_output_enable && req_in.addr[15:14] == 2'h2 |->
		pins_out.extended_page_address == req_in.program_page_select)
		else $error("page lines wrong");
	a_page_fill: assert property (!cs_n && !(req_in.expanded &&
		req_in.page_lines_output_enable && req_in.addr[15:14] == 2'h2) &&
		!(req_in.narrow && req_in.word) |->
		pins_out.extended_page_address == {PAGE_FILL, req_in.addr[15:14]})
		else $error("page fill wrong");
	a_linear_addr: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		rsp_valid_out && !(req_in.narrow && req_in.word) |->
		rsp_linear_out == {req_in.program_page_select, req_in.addr[13:0]})
		else $error("linear address wrong");
	c_read: cover property ($fell(cs_n) && pins_out.rw);
	c_write: cover property ($fell(cs_n) && !pins_out.rw);
	c_long: cover property ($fell(cs_n) ##1 (!cs_n)[*8]);
endmodule

bind ebs_bus_sequencer ebs_bus_sequencer_checker u_chk (.clk_in(clk_in),
	.rst_n_in(rst_n_in), .link_clk_in(link_clk_in), .req_in(req_in),
	.req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
	.rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out),
	.rsp_linear_out(rsp_linear_out), .pins_out(pins_out), .ad_in(ad_in));

// File: ebs_mem_model.sv
// Purpose: byte memory behind the multiplexed bus
// Assumes: address seen while driven and not selected
// Notes: unselected data lines toggle so stale values never pass
`timescale 1ns/1ps
module ebs_mem_model (
	// link clock
	input wire logic link_clk_in,
	// bus
	input wire ebs_pkg::ebs_pins_t pins_in,
	output logic [ebs_pkg::DATA_W-1:0] ad_out
);
	import ebs_pkg::*;
	logic [7:0] mem [0:16383];
	logic [13:0] a_ff;
	wire logic sel = !(pins_in.emulation_chip_select_n &
		pins_in.expansion_chip_select_n);
	initial ad_out = 16'h0000;
	always @(posedge link_clk_in)
	begin
		if (pins_in.ad_oe && !pins_in.bus_clock_out && !sel)
			a_ff <= pins_in.ad[13:0];
		if (sel && !pins_in.rw && pins_in.ad_oe && pins_in.bus_clock_out)
		begin
			mem[a_ff] <= pins_in.ad[15:8];
			if (!pins_in.low_byte_strobe_n && !a_ff[0])
				mem[a_ff + 14'h1] <= pins_in.ad[7:0];
		end
		// released bus toggles rather than holding the last value
		ad_out <= (sel && pins_in.rw) ? {mem[a_ff], mem[a_ff + 14'h1]} :
			~ad_out;
	end
endmodule

// File: ebs_bus_sequencer_tb.sv
// Purpose: directed bench for the bus cycle sequencer
// Assumes: link clock 125 ns, system clock 5 ns
// Notes: memory model answers with no wait of its own
`timescale 1ns/1ps
module ebs_bus_sequencer_tb;
	import ebs_pkg::*;
	logic clk_in = 1'b0;
	logic link_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic req_valid_in = 1'b0;
	ebs_req_t req_in = '0;
	logic req_ready_out, rsp_valid_out;
	logic [DATA_W-1:0] rsp_rdata_out, ad_in;
	logic [19:0] rsp_linear_out;
	ebs_pins_t pins_out;
	int n_mismatch = 0;
	int checked = 0;
	logic page_en = 1'b1;
	always #2.5 clk_in = ~clk_in;
	// offset keeps link edges off the system clock edges
	initial
	begin
		#1.2;
		forever #62.5 link_clk_in = ~link_clk_in;
	end
	ebs_bus_sequencer DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.link_clk_in(link_clk_in), .req_in(req_in),
		.req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
		.rsp_valid_out(rsp_valid_out), .rsp_rdata_out(rsp_rdata_out),
		.rsp_linear_out(rsp_linear_out), .pins_out(pins_out), .ad_in(ad_in));
	ebs_mem_model mem (.link_clk_in(link_clk_in), .pins_in(pins_out),
		.ad_out(ad_in));
	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// f holds write, word, narrow, emulation select
	task automatic go(input logic [15:0] a, input logic [3:0] f,
		input logic [15:0] d, input logic [1:0] s, input logic [5:0] pg);
		int n;
		@(posedge clk_in);
		#1;
		req_in = '{addr:a, write:f[3], word:f[2], wdata:d, stretch:s,
			program_page_select:pg, narrow:f[1], expanded:1'b1,
			page_lines_output_enable:page_en, emul_sel:f[0]};
		req_valid_in = 1'b1;
		while (req_ready_out !== 1'b1)
		begin
			@(posedge clk_in);
			#1;
		end
		@(posedge clk_in);
		#1;
		req_valid_in = 1'b0;
		n = 0;
		while (rsp_valid_out !== 1'b1 && n < 9999)
		begin
			@(posedge clk_in);
			#1;
			n++;
		end
		check(n < 9999, 1'b1);
	endtask
	task automatic t_split;
		go(16'h1230, 4'b1110, 16'ha55a, 2'h0, 6'h00);
		check(mem.mem[14'h1230], 8'ha5);
		check(mem.mem[14'h1231], 8'h5a);
		go(16'h1230, 4'b0110, 16'h0000, 2'h1, 6'h00);
		check(rsp_rdata_out, 16'ha55a);
	endtask
	task automatic t_reads;
		go(16'h1230, 4'b0101, 16'h0000, 2'h0, 6'h00);
		check(rsp_rdata_out, 16'ha55a);
		go(16'h1231, 4'b0010, 16'h0000, 2'h2, 6'h00);
		check(rsp_rdata_out, 16'h005a);
	endtask
	task automatic t_stretch;
		logic [15:0] d;
		for (int s = 0; s < 4; s++)
		begin
			d = 16'h1234 + 16'(s);
			go(16'h2000 + 16'(2 * s), {3'b110, s[0]}, d, s[1:0], 6'h00);
			check(mem.mem[14'h2000 + 14'(2 * s)], d[15:8]);
			check(mem.mem[14'h2001 + 14'(2 * s)], d[7:0]);
		end
	endtask
	task automatic t_page;
		go(16'h9230, 4'b0100, 16'h0000, 2'h3, 6'h3b);
		check(rsp_rdata_out, 16'ha55a);
		check(rsp_linear_out, 20'hed230);
		check(rsp_linear_out / 20'h04000, 20'h0003b);
		// page lines disabled: window access shows the fill value instead
		page_en = 1'b0;
		go(16'h9230, 4'b0100, 16'h0000, 2'h1, 6'h3b);
		page_en = 1'b1;
		check(rsp_rdata_out, 16'ha55a);
		check(rsp_linear_out, 20'hed230);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		#300000;
		n_mismatch++;
		tally_and_finish();
	end
	initial
	begin
		repeat (16) @(posedge clk_in);
		// link side needs three of its own edges to take the reset
		repeat (3) @(posedge link_clk_in);
		@(posedge clk_in);
		#1;
		rst_n_in = 1'b1;
		repeat (3) @(posedge link_clk_in);
		t_split();
		t_reads();
		t_stretch();
		t_page();
		tally_and_finish();
	end
endmodule
